//--- hdl/mrt_map.svh
// register map constants for the second/third mode register block
// Functional notes
// [R1] second mode register holds until rewritten
// [R2] controller writes only when idle, then waits
// [R3] controller zeroes reserved second register bits
// [R4] bits 5:3 give cas write latency
// [R5] auto self refresh doubles rate when hot
// [R6] extended temp bit forces double rate
// [R7] controller never sets both refresh bits
// [R8] extended range needs double refresh options
// [R9] bits 10:9 pick write termination value
// [R10] write termination during each write burst
// [R11] nominal off means high impedance
// [R12] no write termination during write leveling
// [R13] controller zeroes reserved third register bits
// [R14] bit 2 redirects reads to readout
// [R15] mode 00 selects calibration pattern
// [R16] controller precharges before enabling readout
// [R17] reads redirected to readout while enabled
// [R18] controller issues only reads while enabled
// [R19] readout on prime line or all lines
// [R20] eight beat and chop bursts supported
// [R21] address bit 2 picks nibble order
// [R22] first beat is lsb, last msb
// [R23] calibration pattern alternates zero one
// [R24] bank bits select target mode register
// [R25] controller waits recovery before disabling readout
// [R26] latency field decoded with standard mapping
`ifndef MRT_MAP_SVH
`define MRT_MAP_SVH
`define MRT_BA_MR2        3'h2
`define MRT_BA_MR3        3'h3
`define MRT_CWL_LSB       3
`define MRT_CWL_MSB       5
`define MRT_ASR_BIT       6
`define MRT_SRT_BIT       7
`define MRT_RTTWR_LSB     9
`define MRT_RTTWR_MSB     10
`define MRT_MPR_EN_BIT    2
`define MRT_MPR_SEL_MSB   1
`define MRT_MPR_SEL_PRE   2'h0
`define MRT_CWL_BASE      4'h5
`define MRT_PATTERN       8'haa
`define MRT_REG_RESET     18'h00000
`define MRT_BURST_BL8     4'h8
`define MRT_BURST_BC4     4'h4
`define MRT_TEMP_LIMIT_C  8'h55
`define MRT_TEMP_EARLY_C  8'h53
`endif

//--- hdl/mrt_pkg.sv
// types for the second/third mode register block
package mrt_pkg;
  typedef enum logic [1:0] {MRT_RD_IDLE, MRT_RD_BURST} mrt_rd_e;
endpackage

//--- hdl/mrt_cwl_decode.sv
// cas write latency field decoder
`timescale 1ns/1ps
`include "mrt_map.svh"
module mrt_cwl_decode (
  input  wire logic [2:0] field,  // latency field
  output logic      [3:0] cycles  // latency in clocks
);
  // standard mapping: code n gives n plus five clocks
  always_comb begin
    cycles = `MRT_CWL_BASE + {1'b0, field}; // [R26] [R4]
  end
endmodule

//--- hdl/mrt_readout_pattern.sv
// readout pattern source for one burst
`timescale 1ns/1ps
`include "mrt_map.svh"
module mrt_readout_pattern (
  input  wire logic [1:0] sel,     // readout mode
  input  wire logic       nib_hi,  // upper nibble start
  input  wire logic       chop,    // four beat burst
  output logic      [7:0] beats,   // beat k in bit k
  output logic            valid    // mode defined
);
  // only the predefined mode is defined; others return zeros
  always_comb begin
    valid = (sel == `MRT_MPR_SEL_PRE);      // [R15]
    beats = valid ? `MRT_PATTERN : 8'h00;   // [R23] [R22]
    if (chop && nib_hi) begin
      beats = {4'h0, beats[7:4]};           // [R21]
    end
  end
endmodule

//--- hdl/mrt_mode_regs.sv
// second and third mode register state and readout datapath
`timescale 1ns/1ps
`include "mrt_map.svh"
module mrt_mode_regs #(
  parameter int DQ_WIDTH = 8  // data lines
) (
  input  wire logic                clock,         // command clock
  input  wire logic                rst,           // sync reset, high
  input  wire logic                mrs_cmd,       // mode set pulse
  input  wire logic                rd_cmd,        // read or read_with_auto_precharge pulse
  input  wire logic                wr_cmd,        // write pulse
  input  wire logic [2:0]          ba,            // bank address
  input  wire logic [17:0]         addr,          // mode data / address
  input  wire logic                chop_addr,     // a12, high = bl8
  input  wire logic                otf_en,        // on the fly enabled
  input  wire logic                bc4_fixed,     // fixed chop mode
  input  wire logic                all_lines,     // drive all dq
  input  wire logic                lvl_active,    // write leveling
  input  wire logic                nom_on,        // nominal term enabled
  input  wire logic [7:0]          case_temp_c,   // case temperature
  input  wire logic [3:0]          read_latency,  // al plus cl
  input  wire logic [3:0]          add_latency,   // additive latency
  input  wire logic                wr_burst,      // write burst active
  output logic      [17:0]         mode_reg_two,  // stored copy
  output logic      [17:0]         mode_reg_three,// stored copy
  output logic      [3:0]          write_latency, // cwl plus al
  output logic                     double_rate,   // 2x self refresh
  output logic      [1:0]          term_sel,      // 0 hiz 1 nom 2 wr
  output logic      [1:0]          wr_term_value, // write term code
  output logic                     readout_on,    // readout enabled
  output logic                     array_rd,      // read goes to array
  output logic      [DQ_WIDTH-1:0] dq_out,        // readout data
  output logic                     dq_oe          // readout driving
);
  typedef struct packed {
    logic [17:0]     mr2;
    logic [17:0]     mr3;
    mrt_pkg::mrt_rd_e st;
    logic [3:0]      wait_cnt;
    logic [3:0]      beat;
    logic [3:0]      len;
    logic [7:0]      beats;
    logic            hot;
    logic [DQ_WIDTH-1:0] dq;
    logic            oe;
  } mrt_state_s;

  mrt_state_s s_reg;
  mrt_state_s s_next;
  logic [3:0] cwl_cycles;
  logic [7:0] pat_beats;
  logic       pat_valid;
  logic       chop;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  mrt_cwl_decode u_cwl (
    .field  (s_reg.mr2[`MRT_CWL_MSB:`MRT_CWL_LSB]),
    .cycles (cwl_cycles)
  );

  // burst chop from a12 when on the fly, else fixed mode
  assign chop = otf_en ? ~chop_addr : bc4_fixed; // [R20]

  mrt_readout_pattern u_pat (
    .sel    (s_reg.mr3[`MRT_MPR_SEL_MSB:0]),
    .nib_hi (addr[2]),
    .chop   (chop),
    .beats  (pat_beats),
    .valid  (pat_valid)
  );

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  // a new read while a burst runs is ignored; controller spaces reads
  always_comb begin
    s_next = s_reg;
    s_next.oe = 1'b0;
    s_next.dq = '0;
    // registers change only on a matching mode set or on reset
    if (mrs_cmd && ba == `MRT_BA_MR2) begin
      s_next.mr2 = addr; // [R1] [R24]
    end
    if (mrs_cmd && ba == `MRT_BA_MR3) begin
      s_next.mr3 = addr; // [R24]
    end
    // hysteresis-free early switch keeps integrity below the limit
    s_next.hot = (case_temp_c >= `MRT_TEMP_EARLY_C); // [R5]
    unique case (s_reg.st)
      mrt_pkg::MRT_RD_IDLE: begin
        if (rd_cmd && s_reg.mr3[`MRT_MPR_EN_BIT]) begin
          s_next.st       = mrt_pkg::MRT_RD_BURST; // [R17]
          s_next.wait_cnt = read_latency;
          s_next.beat     = 4'h0;
          s_next.len      = chop ? `MRT_BURST_BC4 : `MRT_BURST_BL8;
          s_next.beats    = pat_beats;
        end
      end
      mrt_pkg::MRT_RD_BURST: begin
        if (s_reg.wait_cnt != 4'h0) begin
          s_next.wait_cnt = s_reg.wait_cnt - 4'h1; // [R20]
        end else begin
          s_next.oe = 1'b1;
          // prime lines 0 and 8 carry data, others low, unless all lines
          for (int i = 0; i < DQ_WIDTH; i++) begin
            s_next.dq[i] = (all_lines || i == 0 || i == 8) ?
                           s_reg.beats[s_reg.beat[2:0]] : 1'b0; // [R19]
          end
          s_next.beat = s_reg.beat + 4'h1; // [R22]
          if (s_reg.beat + 4'h1 == s_reg.len) begin
            s_next.st = mrt_pkg::MRT_RD_IDLE;
          end
        end
      end
    endcase
    if (rst) begin
      s_next = '0;
      s_next.mr2 = `MRT_REG_RESET;
      s_next.mr3 = `MRT_REG_RESET;
      s_next.st  = mrt_pkg::MRT_RD_IDLE;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign mode_reg_two   = s_reg.mr2;
  assign mode_reg_three = s_reg.mr3;
  assign write_latency  = cwl_cycles + add_latency; // [R4]
  // forced rate wins; auto follows temperature
  assign double_rate = s_reg.mr2[`MRT_SRT_BIT] |
                       (s_reg.mr2[`MRT_ASR_BIT] & s_reg.hot); // [R6] [R5]
  assign wr_term_value = s_reg.mr2[`MRT_RTTWR_MSB:`MRT_RTTWR_LSB]; // [R9]
  // write term only in bursts and never while leveling
  always_comb begin
    if (wr_burst && wr_term_value != 2'h0 && !lvl_active) begin
      term_sel = 2'h2; // [R10] [R12]
    end else if (nom_on) begin
      term_sel = 2'h1; // [R11]
    end else begin
      term_sel = 2'h0; // [R11]
    end
  end
  assign readout_on = s_reg.mr3[`MRT_MPR_EN_BIT];
  assign array_rd   = rd_cmd & ~readout_on; // [R14]
  assign dq_out     = s_reg.dq;
  assign dq_oe      = s_reg.oe;
  logic unused_ok;
  assign unused_ok  = wr_cmd & pat_valid;
endmodule

//--- verification/mrt_mode_regs_properties.sv
// timing checker for the mode register block, bound to its ports
`timescale 1ns/1ps
module mrt_mode_regs_chk (
  input wire logic        clock,         // command clock
  input wire logic        rst,           // sync reset
  input wire logic        mrs_cmd,       // mode set
  input wire logic        rd_cmd,        // read
  input wire logic [2:0]  ba,            // bank address
  input wire logic [17:0] addr,          // mode data
  input wire logic [7:0]  case_temp_c,   // case temp
  input wire logic [3:0]  add_latency,   // additive
  input wire logic        wr_burst,      // write burst
  input wire logic        lvl_active,    // leveling
  input wire logic [17:0] mode_reg_two,  // stored copy
  input wire logic [3:0]  write_latency, // total wl
  input wire logic        double_rate,   // 2x refresh
  input wire logic [1:0]  term_sel,      // termination
  input wire logic        readout_on,    // readout mode
  input wire logic        array_rd       // array read
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // a missed or misrouted load shows up one cycle later
  a_mr2_load: assert property (mrs_cmd && ba == 3'h2 |=> mode_reg_two == $past(addr))
    else $error("second mode register not loaded");
  a_mr2_hold: assert property (!(mrs_cmd && ba == 3'h2) |=> $stable(mode_reg_two))
    else $error("second mode register changed");
  a_wl_sum: assert property (write_latency == 4'(mode_reg_two[5:3]) + 4'h5 + add_latency)
    else $error("write latency wrong");
  a_srt_rate: assert property (mode_reg_two[7] |-> double_rate)
    else $error("forced double rate missing");
  a_asr_rate: assert property (mode_reg_two[6] && $past(case_temp_c) > 8'h55 |-> double_rate)
    else $error("hot device not at double rate");
  a_wr_term: assert property (wr_burst && !lvl_active && mode_reg_two[10:9] != 2'h0 |-> term_sel == 2'h2)
    else $error("write termination not applied");
  a_lvl_term: assert property (lvl_active |-> term_sel != 2'h2)
    else $error("write termination during leveling");
  a_rd_route: assert property (rd_cmd |-> array_rd == !readout_on)
    else $error("read routed wrongly");
endmodule
bind mrt_mode_regs mrt_mode_regs_chk u_chk (.clock, .rst, .mrs_cmd, .rd_cmd,
  .ba, .addr, .case_temp_c, .add_latency, .wr_burst, .lvl_active,
  .mode_reg_two, .write_latency, .double_rate, .term_sel, .readout_on,
  .array_rd);

//--- verification/mrt_ctrl_model.sv
// memory controller model issuing mode set and read commands
`timescale 1ns/1ps
module mrt_ctrl_model #(
  parameter int MOD_WAIT = 4  // mode cycle plus update delay
) (
  input  wire logic        clock,            // command clock
  output logic             mrs_cmd = 1'b0,   // mode set
  output logic             rd_cmd = 1'b0,    // read
  output logic [2:0]       ba = 3'h0,        // bank address
  output logic [17:0]      addr = 18'h00000, // address
  output logic             chop_addr = 1'b1  // a12
);
  // released lines invert so a stale value is never mistaken for data
  task automatic mode_register_set_cmd(input logic [2:0] sel, input logic [17:0] val);
    @(negedge clock);
    mrs_cmd = 1'b1;
    ba = sel;
    addr = val;
    @(negedge clock);
    mrs_cmd = 1'b0;
    ba = ~sel;
    addr = ~val;
    repeat (MOD_WAIT) @(negedge clock);
  endtask
  // one read; callers space reads past the end of the burst
  task automatic rd(input logic a2, input logic bl8);
    @(negedge clock);
    rd_cmd = 1'b1;
    addr = {15'h0000, a2, 2'h0};
    chop_addr = bl8;
    @(negedge clock);
    rd_cmd = 1'b0;
    addr = ~addr;
    chop_addr = ~bl8;
  endtask
endmodule

//--- verification/mrt_mode_regs_tb_top.sv
// self-checking bench for the mode register block
`timescale 1ns/1ps
module mrt_mode_regs_tb_top;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        all_lines = 1'b0;
  logic        lvl_active = 1'b0;
  logic        nom_on = 1'b0;
  logic        wr_burst = 1'b0;
  logic [7:0]  case_temp_c = 8'h40;
  logic [3:0]  add_latency = 4'h2;
  logic        mrs_cmd, rd_cmd, chop_addr, array_rd, double_rate;
  logic        readout_on, dq_oe;
  logic [2:0]  ba;
  logic [17:0] addr, mode_reg_two, mode_reg_three;
  logic [3:0]  write_latency;
  logic [1:0]  term_sel, wr_term_value;
  logic [7:0]  dq_out;
  int          miscompares = 0;
  int          checked = 0;
  mrt_ctrl_model ctrl (.clock, .mrs_cmd, .rd_cmd, .ba, .addr, .chop_addr);
  // read latency fixed at 5 so burst timing is easy to count
  mrt_mode_regs dut (.clock, .rst, .mrs_cmd, .rd_cmd, .wr_cmd(1'b0), .ba,
    .addr, .chop_addr, .otf_en(1'b1), .bc4_fixed(1'b0), .all_lines,
    .lvl_active, .nom_on, .case_temp_c, .read_latency(4'h5), .add_latency,
    .wr_burst, .mode_reg_two, .mode_reg_three, .write_latency, .double_rate,
    .term_sel, .wr_term_value, .readout_on, .array_rd, .dq_out, .dq_oe);
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_mr2();
    ctrl.mode_register_set_cmd(3'h2, 18'h00090);
    chk(mode_reg_two, 18'h00090);
    chk(write_latency, 4'h9);
    chk(double_rate, 1'b1);
    ctrl.mode_register_set_cmd(3'h3, 18'h00000);
    chk(mode_reg_two, 18'h00090);
    ctrl.mode_register_set_cmd(3'h2, 18'h00040);
    chk(double_rate, 1'b0);
    case_temp_c = 8'h56;
    @(negedge clock);
    chk(double_rate, 1'b1);
    $display("mode register two test done");
  endtask
  task automatic t_term();
    ctrl.mode_register_set_cmd(3'h2, 18'h00200);
    chk(wr_term_value, 2'h1);
    wr_burst = 1'b1;
    nom_on = 1'b1;
    @(negedge clock);
    chk(term_sel, 2'h2);
    lvl_active = 1'b1;
    @(negedge clock);
    chk(term_sel === 2'h2, 1'b0);
    lvl_active = 1'b0;
    wr_burst = 1'b0;
    @(negedge clock);
    chk(term_sel, 2'h1);
    nom_on = 1'b0;
    @(negedge clock);
    chk(term_sel, 2'h0);
    $display("termination test done");
  endtask
  // beat k carries the low bit of k: the pattern alternates from zero
  task automatic burst(input logic a2, input logic all, input int n);
    all_lines = all;
    ctrl.rd(a2, n == 8);
    repeat (5) @(negedge clock);
    chk(dq_oe, 1'b0);
    for (int k = 0; k < n; k++) begin
      @(negedge clock);
      chk(dq_oe, 1'b1);
      chk(dq_out, all ? {8{k[0]}} : {7'h00, k[0]});
    end
    @(negedge clock);
    chk(dq_oe, 1'b0);
  endtask
  task automatic t_readout();
    ctrl.mode_register_set_cmd(3'h3, 18'h00004);
    chk(readout_on, 1'b1);
    chk(mode_reg_three, 18'h00004);
    burst(1'b0, 1'b1, 8);
    burst(1'b1, 1'b0, 4);
    ctrl.mode_register_set_cmd(3'h3, 18'h00000);
    chk(readout_on, 1'b0);
    // the array strobe is a pulse, so look while the read stands
    fork
      ctrl.rd(1'b0, 1'b1);
      begin
        @(negedge clock);
        #1;
        chk(array_rd, 1'b1);
      end
    join
    repeat (6) @(negedge clock);
    chk(dq_oe, 1'b0);
    $display("readout test done");
  endtask
  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    t_mr2();
    t_term();
    t_readout();
    final_report();
  end
  // all tests need well under 300 cycles; this gives ample margin
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    final_report();
  end
endmodule
